// file: bcr_board_ctl.sv
/*
 * Board control bus, clock phases, reset and load logic.
 * Assumes a processor core on i_clk_sys issuing memory and serial I/O requests,
 * and external pins that are asynchronous to i_clk_sys.
 */
`include "bcr_regs.svh"
`default_nettype none

module bcr_board_ctl
    import bcr_pkg::*;
#(
    parameter logic [1:0] LOAD_PULSES = `BCR_LOAD_PULSES
) (
    // Clock and reset
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_reset_n,
    // Clock phases
    output logic [3:0]                      o_phase,
    output logic [3:0]                      o_phase_n,
    // Reset and load pins
    input  wire logic                       i_reset_button_n,
    input  wire logic                       i_ext_reset_n,
    input  wire logic                       i_ext_restart_n,
    output logic                            o_cpu_reset_n,
    output logic                            o_periph_clear_n,
    output logic                            o_load_n,
    output logic                            o_trap_req,
    output logic [15:0]                     o_trap_wp_addr,
    output logic [15:0]                     o_trap_pc_addr,
    // Interrupt mask
    input  wire logic                       i_mask_wr,
    input  wire logic [`BCR_MASK_W-1:0]     i_mask_val,
    output logic      [`BCR_MASK_W-1:0]     o_int_mask,
    // Core memory requests
    input  wire logic                       i_mem_req,
    input  wire logic                       i_mem_write,
    input  wire logic                       i_mem_fetch,
    input  wire logic [`BCR_ADDR_W-1:0]     i_mem_addr,
    input  wire logic [`BCR_DATA_W-1:0]     i_mem_wdata,
    output logic                            o_mem_done,
    output logic      [`BCR_DATA_W-1:0]     o_mem_rdata,
    // Core serial I/O requests
    input  wire logic                       i_io_req,
    input  wire logic                       i_io_write,
    input  wire logic [`BCR_ADDR_W-1:0]     i_io_addr,
    input  wire logic                       i_io_wbit,
    output logic                            o_io_done,
    output logic                            o_io_rbit,
    // Memory bus pins
    output logic      [`BCR_ADDR_W-1:0]     o_addr,
    output logic                            o_bus_oe,
    output logic                            o_mem_select_n,
    output logic                            o_bus_dir_in,
    output logic                            o_write_n,
    output logic                            o_mem_cycle_n,
    output logic                            o_fetch_indicator,
    output logic      [`BCR_DATA_W-1:0]     o_data,
    output logic                            o_data_oe,
    input  wire logic [`BCR_DATA_W-1:0]     i_data,
    input  wire logic                       i_ready,
    output logic                            o_wait,
    input  wire logic                       i_hold_n,
    output logic                            o_bus_grant,
    // Serial I/O pins
    input  wire logic                       i_serial_io_in,
    output logic                            o_serial_io_out,
    output logic                            o_serial_io_strobe,
    // Interrupt lines, bit k is line k+1
    input  wire logic [`BCR_IRQ_LINES-1:0]  i_irq_lines_n,
    output logic      [`BCR_IRQ_CODE_W-1:0] o_irq_code,
    output logic                            o_irq_valid
);
    // ==========================================================
    // Pin synchronisers
    logic [`BCR_PIN_W-1:0]     pins_s;
    logic                      button_s;
    logic                      ext_reset_s;
    logic                      restart_s;
    logic                      ready_s;
    logic                      hold_req;
    logic                      serial_s;
    logic [`BCR_IRQ_LINES-1:0] irq_s;
    logic [`BCR_DATA_W-1:0]    data_s;

    // Data and ready share the same lag, so read data lines up with ready
    bcr_sync #(
        .W       (`BCR_PIN_W),
        .RST_VAL (`BCR_PIN_RST)
    ) u_pin_sync (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_async   ({i_data, i_irq_lines_n, i_serial_io_in, i_hold_n, i_ready,
                     i_ext_restart_n, i_ext_reset_n, i_reset_button_n}),
        .o_sync    (pins_s)
    );

    assign button_s    = pins_s[0];
    assign ext_reset_s = pins_s[1];
    assign restart_s   = pins_s[2];
    assign ready_s     = pins_s[3];
    assign hold_req    = !pins_s[4];
    assign serial_s    = pins_s[5];
    assign irq_s       = pins_s[20:6];
    assign data_s      = pins_s[36:21];

    // ==========================================================
    // Clock phases
    logic [3:0] phase;
    logic       ph3_tick;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase <= `BCR_PHASE_RST;
        end else begin
            phase <= {phase[2:0], phase[3]}; // RL13
        end
    end

    assign ph3_tick  = phase[`BCR_PH3_BIT];
    assign o_phase   = phase;
    assign o_phase_n = ~phase; // RL13

    // ==========================================================
    // Reset capture and release on phase three
    logic reset_req;
    logic reset_latch;
    logic cpu_rst_act;
    logic cpu_rst_prev;
    logic rst_rise;
    logic rst_fall;

    assign reset_req = !button_s || !ext_reset_s; // RL14

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            reset_latch  <= 1'b1;
            cpu_rst_act  <= 1'b1;
            cpu_rst_prev <= 1'b1;
        end else begin
            // Latch keeps a short request alive until the next phase three
            reset_latch  <= reset_req || (reset_latch && !ph3_tick); // RL15
            cpu_rst_prev <= cpu_rst_act;
            if (ph3_tick) begin
                cpu_rst_act <= reset_latch || reset_req; // RL15
            end
        end
    end

    assign o_cpu_reset_n = !cpu_rst_act;
    assign rst_rise      = cpu_rst_act && !cpu_rst_prev;
    assign rst_fall      = !cpu_rst_act && cpu_rst_prev;

    // ==========================================================
    // Bus sequencer
    bcr_state_t             state;
    bcr_state_t             next_state;
    logic                   write_q;
    logic                   fetch_q;
    logic                   in_mem;
    logic                   go_mem;
    logic                   go_io;
    logic [2:0]             ext_code;
    logic                   io_strobe_raw;
    logic                   ext_strobe;
    logic                   io_reset_instr;
    logic                   delayed_load_instr;
    logic                   idle_instr;
    logic                   io_dwell;

    always_comb begin
        next_state = state;
        unique case (state)
            BCR_IDLE: begin
                // Reset holds the sequencer idle: no writes, no serial I/O
                if (cpu_rst_act) begin // RL18
                    next_state = BCR_IDLE;
                end else if (hold_req) begin // RL7
                    next_state = BCR_HELD;
                end else if (i_mem_req) begin
                    next_state = BCR_MEM_ADDR;
                end else if (i_io_req) begin
                    next_state = BCR_IO_ADDR;
                end
            end
            BCR_MEM_ADDR: next_state = BCR_MEM_WAIT;
            BCR_MEM_WAIT: begin
                if (ready_s) begin // RL11 RL5
                    next_state = BCR_MEM_END;
                end
            end
            BCR_MEM_END:  next_state = BCR_IDLE;
            BCR_IO_ADDR:  next_state = io_dwell ? BCR_IO_END : BCR_IO_ADDR;
            BCR_IO_END:   next_state = BCR_IDLE;
            BCR_HELD: begin
                if (!hold_req) begin
                    next_state = BCR_IDLE;
                end
            end
            default:      next_state = BCR_IDLE;
        endcase
    end

    assign go_mem = (state == BCR_IDLE) && (next_state == BCR_MEM_ADDR);
    assign go_io  = (state == BCR_IDLE) && (next_state == BCR_IO_ADDR);
    assign in_mem = (state == BCR_MEM_ADDR) || (state == BCR_MEM_WAIT)
                 || (state == BCR_MEM_END);

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state           <= BCR_IDLE;
            o_addr          <= '0;
            write_q         <= 1'b0;
            fetch_q         <= 1'b0;
            o_data          <= '0;
            o_serial_io_out <= 1'b0;
            io_dwell        <= 1'b0;
        end else begin
            state <= next_state;
            io_dwell <= (state == BCR_IO_ADDR) && !io_dwell;
            if (go_mem) begin // RL10
                o_addr  <= i_mem_addr;
                write_q <= i_mem_write;
                fetch_q <= i_mem_fetch;
                o_data  <= i_mem_wdata;
            end else if (go_io) begin
                o_addr          <= i_io_addr;
                write_q         <= i_io_write;
                fetch_q         <= 1'b0;
                o_serial_io_out <= i_io_wbit; // RL12
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mem_done  <= 1'b0;
            o_mem_rdata <= '0;
            o_io_done   <= 1'b0;
            o_io_rbit   <= 1'b0;
            o_bus_oe    <= 1'b1;
            o_bus_grant <= 1'b0;
        end else begin
            o_mem_done <= (state == BCR_MEM_END);
            o_io_done  <= (state == BCR_IO_END);
            if ((state == BCR_MEM_END) && !write_q) begin
                o_mem_rdata <= data_s;
            end
            // Serial input is looked at only in the input slot
            if ((state == BCR_IO_END) && !write_q) begin
                o_io_rbit <= serial_s; // RL12
            end
            o_bus_oe    <= (next_state != BCR_HELD);
            // Grant follows one cycle after the drivers are already off
            o_bus_grant <= (state == BCR_HELD) && (next_state == BCR_HELD); // RL8
        end
    end

    assign o_mem_select_n    = !in_mem; // RL1
    assign o_mem_cycle_n     = !((state == BCR_MEM_ADDR) || (state == BCR_MEM_WAIT)); // RL4
    assign o_bus_dir_in      = !(in_mem && write_q); // RL2
    assign o_write_n         = !((state == BCR_MEM_WAIT) && write_q && !cpu_rst_act); // RL3 RL18
    assign o_fetch_indicator = in_mem && fetch_q; // RL9
    assign o_wait            = (state == BCR_MEM_WAIT) && !ready_s; // RL6
    assign o_data_oe         = in_mem && write_q;

    // ==========================================================
    // Serial strobe and external instruction decode
    assign ext_code      = o_addr[`BCR_ADDR_W-1 -: 3];
    assign io_strobe_raw = (state == BCR_IO_END) && write_q && !cpu_rst_act; // RL18
    assign o_serial_io_strobe = io_strobe_raw && o_mem_select_n
                             && (ext_code == `BCR_EXT_CRU); // RL22
    assign ext_strobe         = io_strobe_raw && (ext_code != `BCR_EXT_CRU);
    assign io_reset_instr     = ext_strobe && (ext_code == `BCR_EXT_IO_RESET_INSTR);
    assign delayed_load_instr = ext_strobe && (ext_code == `BCR_EXT_DELAYED_LOAD_INSTR);
    assign idle_instr         = ext_strobe && (ext_code == `BCR_EXT_IDLE);

    // ==========================================================
    // Peripheral clear pulse and interrupt mask
    logic clr_trig;
    logic clr_pend;
    logic clr_stg1;
    logic clr_stg2;

    // Reset-I/O feeds this pulse and the interrupt mask clear, never the processor reset
    assign clr_trig = rst_rise || io_reset_instr; // RL17

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            clr_pend <= 1'b1;
            clr_stg1 <= 1'b0;
            clr_stg2 <= 1'b0;
        end else begin
            clr_pend <= clr_trig || (clr_pend && !ph3_tick);
            if (ph3_tick) begin
                clr_stg1 <= clr_pend; // RL16
                clr_stg2 <= clr_stg1; // RL16
            end
        end
    end

    // Low from one phase-three tick to the next: one full period
    assign o_periph_clear_n = !(clr_stg1 && !clr_stg2); // RL16 RL25

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_int_mask <= '0;
        end else if (cpu_rst_act || io_reset_instr) begin
            o_int_mask <= '0; // RL19
        end else if (i_mask_wr) begin
            o_int_mask <= i_mask_val;
        end
    end

    // ==========================================================
    // Delayed load
    logic       restart_prev;
    logic       load_set;
    logic       load_req;
    logic       load_take;
    logic       armed;
    logic [1:0] load_cnt;
    logic [1:0] cnt_next;
    logic       count_pulse;
    logic       load_fire;

    // Edge, not level: a held restart line gives one load
    assign load_set    = (restart_prev && !restart_s) || delayed_load_instr; // RL20 RL24
    assign load_take   = load_req && !armed;
    assign count_pulse = ((state == BCR_MEM_ADDR) && fetch_q) || idle_instr;
    assign cnt_next    = load_cnt + 2'h1;
    assign load_fire   = armed && count_pulse && (cnt_next == LOAD_PULSES)
                      && !cpu_rst_act;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            restart_prev <= 1'b1;
            load_req     <= 1'b0;
            armed        <= 1'b0;
            load_cnt     <= '0;
        end else begin
            restart_prev <= restart_s;
            if (cpu_rst_act) begin
                load_req <= 1'b0; // RL23
                armed    <= 1'b0; // RL23
                load_cnt <= '0;
            end else begin
                load_req <= load_set || (load_req && !load_take); // RL24
                if (load_take) begin
                    armed    <= 1'b1;
                    load_cnt <= '0;
                end else if (armed && count_pulse) begin
                    load_cnt <= cnt_next; // RL24
                    armed    <= !load_fire;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_load_n       <= 1'b1;
            o_trap_req     <= 1'b0;
            o_trap_wp_addr <= `BCR_RST_WP;
            o_trap_pc_addr <= `BCR_RST_PC;
        end else begin
            o_load_n   <= !load_fire; // RL20
            o_trap_req <= rst_fall || load_fire;
            if (rst_fall) begin
                o_trap_wp_addr <= `BCR_RST_WP; // RL19
                o_trap_pc_addr <= `BCR_RST_PC; // RL19
            end else if (load_fire) begin
                o_trap_wp_addr <= `BCR_LOAD_WP;
                o_trap_pc_addr <= `BCR_LOAD_PC;
            end
        end
    end

    // ==========================================================
    // Interrupt encoder, lowest line number wins
    logic [`BCR_IRQ_CODE_W-1:0] irq_code_next;

    always_comb begin
        irq_code_next = '0;
        for (int i = `BCR_IRQ_LINES - 1; i >= 0; i--) begin
            if (!irq_s[i]) begin
                irq_code_next = 4'(i + 1); // RL21
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_irq_code  <= '0;
            o_irq_valid <= 1'b0;
        end else begin
            o_irq_code  <= irq_code_next;
            o_irq_valid <= (irq_code_next != '0);
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    mem_cycle_end_a: assert property ((state == BCR_MEM_WAIT) && ready_s // RL11
        |=> o_mem_cycle_n && !o_mem_select_n ##1 o_mem_select_n)
        else $error("memory cycle did not end one clock after ready");
    wait_state_a: assert property (o_wait |-> !o_mem_cycle_n && !ready_s) // RL6
        else $error("wait shown outside a not-ready memory cycle");
    grant_after_release_a: assert property ($rose(o_bus_grant) // RL8
        |-> !o_bus_oe && !$past(o_bus_oe))
        else $error("grant raised before buses were released");
    write_strobe_a: assert property (!o_write_n // RL3
        |-> !o_mem_select_n && !o_bus_dir_in && !o_mem_cycle_n)
        else $error("write strobe outside a memory write cycle");
    reset_suppress_a: assert property (cpu_rst_act // RL18
        |-> o_write_n && !o_serial_io_strobe && o_load_n)
        else $error("write, serial strobe or load during reset");
    clear_length_a: assert property ($fell(o_periph_clear_n) // RL16
        |=> !o_periph_clear_n [*3] ##1 o_periph_clear_n)
        else $error("peripheral clear not one phase-three period");
    reset_phase_a: assert property ($changed(o_cpu_reset_n) |-> $past(ph3_tick)) // RL15
        else $error("processor reset changed off phase three");
    phase_gen_a: assert property ($onehot(o_phase) && (o_phase_n == ~o_phase)) // RL13
        else $error("clock phases overlap or inverted copy wrong");
    fetch_select_a: assert property (o_fetch_indicator |-> !o_mem_select_n) // RL9
        else $error("fetch indicator without memory select");
    cycle_start_a: assert property (go_mem // RL10
        |=> !o_mem_select_n && o_write_n ##1 (o_write_n == !write_q))
        else $error("memory cycle start order wrong");
endmodule

`default_nettype wire

// file: bcr_regs.svh
/*
 * Named constants of the board control bus and reset block.
 * Assumes it is included by bare name before any module that uses it.
 */
// Notes on behaviour
// RL1: Memory select goes low only while the address is a memory address.
// RL2: Bus direction is high while data flows in, low while driving out.
// RL3: Write strobe pulses low to write data into memory.
// RL4: Memory cycle marker low for each cycle, released between consecutive cycles.
// RL5: Memory holds ready high when data is ready, low for wait states.
// RL6: Wait output is high while memory is not ready.
// RL7: External master pulls hold request low to take the buses.
// RL8: Bus grant rises only after buses are released and activity stopped.
// RL9: Fetch indicator is high during instruction fetch cycles, with memory select.
// RL10: Cycle starts with address, select and direction; write strobe comes later.
// RL11: Memory cycle ends exactly one clock after ready is seen.
// RL12: Serial output bit is strobed; serial input sampled only during input.
// RL13: Input clock divides into four non-overlapping phases plus inverted copies.
// RL14: Either board button or external reset input low requests reset.
// RL15: Reset request is latched and released to processor on third phase.
// RL16: Two flip-flops make peripheral clear, at most two phase-three periods.
// RL17: Reset-I/O instruction makes only peripheral clear, never full reset; the code also zeroes the interrupt mask on it.
// RL18: Reset suppresses memory writes and serial I/O.
// RL19: Reset zeroes interrupt mask, then traps via words 0000 and 0002.
// RL20: Restart low or load instruction requests load after two pulses.
// RL21: Active-low interrupt lines are encoded as a binary number.
// RL22: With select high and top address bits zero, strobe goes out serially.
// RL23: Reset clears load flip-flops, so reset beats a simultaneous load.
// RL24: Load counts two fetch or idle pulses; one load per request.
// RL25: Peripheral clear lasts at least one full phase-three period.
`ifndef BCR_REGS_SVH
`define BCR_REGS_SVH

`define BCR_ADDR_W      15
`define BCR_DATA_W      16
`define BCR_IRQ_LINES   15
`define BCR_IRQ_CODE_W  4
`define BCR_MASK_W      4
`define BCR_PIN_W       37
`define BCR_PIN_RST     37'h00001FFFD7
`define BCR_PHASE_RST   4'h1
`define BCR_PH3_BIT     2
`define BCR_EXT_CRU     3'h0
`define BCR_EXT_IDLE    3'h2
`define BCR_EXT_IO_RESET_INSTR    3'h3
`define BCR_EXT_DELAYED_LOAD_INSTR    3'h7
`define BCR_RST_WP      16'h0000
`define BCR_RST_PC      16'h0002
`define BCR_LOAD_WP     16'hFFFC
`define BCR_LOAD_PC     16'hFFFE
`define BCR_LOAD_PULSES 2'h2

`endif

// file: bcr_pkg.sv
/*
 * Types of the board control bus and reset block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package bcr_pkg;
    typedef enum logic [2:0] {
        BCR_IDLE,
        BCR_MEM_ADDR,
        BCR_MEM_WAIT,
        BCR_MEM_END,
        BCR_IO_ADDR,
        BCR_IO_END,
        BCR_HELD
    } bcr_state_t;
endpackage

`default_nettype wire

// file: bcr_sync.sv
/*
 * Two flip-flop synchroniser for a vector of independent pin levels.
 * Assumes each bit is a slow level; words are not kept coherent.
 */
`default_nettype none

module bcr_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_reset_n,
    // Levels
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta   <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule

`default_nettype wire

// file: bcr_mem_model.sv
/* Memory and serial device model for the board bus.
   Assumes bus pins are sampled on the rising clock edge. */
`default_nettype none
// ================
// Memory device
module bcr_mem_model (
    // Bus pins
    input  wire logic        i_clk_sys,
    input  wire logic [14:0] i_addr,
    input  wire logic        i_sel_n,
    input  wire logic        i_cyc_n,
    input  wire logic        i_dir_in,
    input  wire logic        i_write_n,
    input  wire logic [15:0] i_data,
    input  wire logic [2:0]  i_waits,
    // Answers
    output logic             o_ready,
    output logic      [15:0] o_data,
    output logic             o_serial_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:32767];
    logic [15:0] last = 16'h0;
    int          cnt = 0;
    // Released bus shows a moving pattern, never the last word
    assign o_data      = (!i_sel_n && i_dir_in) ? mem[i_addr] : ~last;
    assign o_ready     = !i_cyc_n && cnt >= i_waits;
    assign o_serial_in = ^i_addr;
    always @(posedge i_clk_sys) begin
        last <= o_data;
        cnt  <= i_cyc_n ? 0 : cnt + 1;
        if (!i_write_n && !i_sel_n) mem[i_addr] <= i_data;
    end
endmodule
`default_nettype wire

// file: board_control_bus_and_reset_tb_top.sv
/* Self-checking bench for the board control block.
   Assumes the memory model answers on the bus pins. */
`default_nettype none
module board_control_bus_and_reset_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk_sys = 0, i_reset_n = 0, i_reset_button_n = 1, i_ext_reset_n = 1, i_mask_wr = 0;
    logic i_ext_restart_n = 1, i_mem_req = 0, i_mem_write = 0, i_mem_fetch = 0, i_io_req = 0;
    logic i_io_write = 0, i_io_wbit = 0, i_hold_n = 1, i_ready, i_serial_io_in;
    logic [3:0]  i_mask_val = 4'h0, o_phase, o_phase_n, o_int_mask, o_irq_code;
    logic [14:0] i_mem_addr = 15'h0, i_io_addr = 15'h0, i_irq_lines_n = 15'h7F3F, o_addr;
    logic [15:0] i_mem_wdata = 16'h0, i_data, mdata, o_trap_wp_addr, o_trap_pc_addr;
    logic [15:0] o_mem_rdata, o_data, exp_mem [int];
    logic o_cpu_reset_n, o_periph_clear_n, o_load_n, o_trap_req, o_mem_done, o_io_done;
    logic o_io_rbit, o_bus_oe, o_mem_select_n, o_bus_dir_in, o_write_n, o_mem_cycle_n;
    logic o_fetch_indicator, o_data_oe, o_wait, o_bus_grant, o_serial_io_out;
    logic o_serial_io_strobe, o_irq_valid, fetch_seen, wait_seen;
    logic [2:0]  waits = 3'h0;
    logic [31:0] trap_v;
    int fail_count = 0, checks_done = 0, seed = 32'h10e1;
    int loads = 0, traps = 0, strobes = 0, clears = 0, clr_run = 0, clr_len = 0;

    bcr_board_ctl uut (.*);
    bcr_mem_model mem (.i_clk_sys, .i_addr(o_addr), .i_sel_n(o_mem_select_n),
        .i_cyc_n(o_mem_cycle_n), .i_dir_in(o_bus_dir_in), .i_write_n(o_write_n),
        .i_data(o_data), .i_waits(waits), .o_ready(i_ready), .o_data(mdata),
        .o_serial_in(i_serial_io_in));
    assign i_data = o_data_oe ? o_data : mdata;

    initial forever #20 i_clk_sys = ~i_clk_sys;
    // ================
    // Event counters
    always @(posedge i_clk_sys) begin
        if (!o_load_n) loads++;
        if (o_trap_req) traps++;
        if (o_trap_req) trap_v = {o_trap_wp_addr, o_trap_pc_addr};
        if (o_serial_io_strobe) strobes++;
        if (!o_mem_select_n && o_fetch_indicator) fetch_seen = 1;
        if (o_wait) wait_seen = 1;
        if (!o_periph_clear_n) clr_run++;
        else if (clr_run > 0) begin
            clears++;
            clr_len = clr_run;
            clr_run = 0;
        end
    end
    // ================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic mem_op(input logic wr, input logic fe, input logic [14:0] a,
                          input logic [15:0] d);
        int k = 0;
        @(negedge i_clk_sys);
        {i_mem_req, i_mem_write, i_mem_fetch, i_mem_addr, i_mem_wdata} = {1'b1, wr, fe, a, d};
        waits = 3'($random(seed) & 3);
        fetch_seen = 0;
        wait_seen = 0;
        do @(negedge i_clk_sys); while (o_mem_done !== 1'b1 && ++k < 100);
        i_mem_req = 0;
        chk({o_mem_done, o_mem_cycle_n}, 2'h3);
        chk(fetch_seen, fe);
        if (waits > 0) chk(wait_seen, 1);
        if (wr) exp_mem[a] = d;
        else chk(o_mem_rdata, exp_mem[a]);
    endtask
    task automatic io_op(input logic wr, input logic [14:0] a);
        int k = 0;
        @(negedge i_clk_sys);
        {i_io_req, i_io_write, i_io_addr, i_io_wbit} = {1'b1, wr, a, 1'($random(seed))};
        do @(negedge i_clk_sys); while (o_io_done !== 1'b1 && ++k < 100);
        i_io_req = 0;
        if (wr) chk({o_io_done, o_serial_io_out}, {1'b1, i_io_wbit});
        else chk({o_io_done, o_io_rbit}, {1'b1, ^a});
    endtask
    task automatic wait_trap(input int t0);
        int k = 0;
        while (traps <= t0 && k++ < 200) @(negedge i_clk_sys);
    endtask
    task automatic conclude();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #400000;
        fail_count++;
        conclude();
    end
    initial begin
        int s0, n0, c0;
        logic [14:0] a;
        repeat (5) @(negedge i_clk_sys);
        i_reset_n = 1;
        wait_trap(0);
        chk(trap_v, 32'h0000_0002);
        repeat (12) @(negedge i_clk_sys);
        chk(clr_len, 4);
        for (int i = 0; i < 8; i++) begin
            a = 15'($random(seed));
            mem_op(1, 0, a, 16'($random(seed)));
            mem_op(0, 1, a, 16'h0);
        end
        s0 = strobes;
        c0 = clears;
        n0 = traps;
        io_op(1, 15'h0155);
        io_op(0, 15'h0ABD);
        io_op(1, 15'h3000);
        repeat (16) @(negedge i_clk_sys);
        chk(strobes - s0, 1);
        chk(clears - c0, 1);
        chk(traps - n0, 0);
        n0 = loads;
        io_op(1, 15'h7000);
        mem_op(0, 1, a, 16'h0);
        chk(loads - n0, 0);
        mem_op(0, 1, a, 16'h0);
        repeat (4) @(negedge i_clk_sys);
        chk(loads - n0, 1);
        chk(trap_v, 32'hFFFC_FFFE);
        mem_op(0, 1, a, 16'h0);
        mem_op(0, 1, a, 16'h0);
        chk(loads - n0, 1);
        {i_ext_restart_n, i_mask_wr, i_mask_val} = {2'h1, 4'hA};
        for (int i = 0; i < 6; i++) mem_op(0, 1, a, 16'h0);
        chk(loads - n0, 2);
        {i_ext_restart_n, i_mask_wr} = 2'h2;
        i_hold_n = 0;
        for (int k = 0; k < 20 && o_bus_grant !== 1'b1; k++) @(negedge i_clk_sys);
        chk({o_bus_grant, o_bus_oe}, 2'h2);
        i_hold_n = 1;
        for (int k = 0; k < 20 && o_bus_grant !== 1'b0; k++) @(negedge i_clk_sys);
        chk({o_bus_grant, o_bus_oe}, 2'h1);
        n0 = loads;
        io_op(1, 15'h7000);
        s0 = traps;
        i_ext_reset_n = 0;
        repeat (6) @(negedge i_clk_sys);
        chk(o_cpu_reset_n, 0);
        i_ext_reset_n = 1;
        wait_trap(s0);
        chk(o_int_mask, 4'h0);
        chk(trap_v, 32'h0000_0002);
        mem_op(0, 1, a, 16'h0);
        mem_op(0, 1, a, 16'h0);
        chk(loads - n0, 0);
        chk({o_irq_valid, o_irq_code}, 5'h17);
        conclude();
    end
endmodule
`default_nettype wire
